// file: src/ubrs_uart.sv
`timescale 1ns/1ps
module ubrs_uart (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst,
    // Register bus
    input  wire ubrs_pkg::ubrs_apb_req_t apb_req,
    output ubrs_pkg::ubrs_apb_rsp_t      apb_rsp,
    // Serial lines
    input  wire logic                   serial_rx_line,
    output logic                        serial_tx_line
);

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ubrs_rx_state_t;
    typedef enum logic {TX_IDLE, TX_SHIFT} ubrs_tx_state_t;

    function automatic logic [20:0] bit_len(input logic [15:0] br, input logic os,
                                            input logic [3:0] brf, input logic [7:0] brs,
                                            input logic [3:0] idx);
        logic [20:0] len;
        len = os ? ({1'b0, br, 4'h0} + {17'h0, brf}) : {5'h0, br};
        len = len + {20'h0, brs[idx[2:0]]};
        if (len == 21'h0) begin
            len = 21'h1;
        end
        return len;
    endfunction : bit_len

    function automatic logic mapped(input logic [7:0] a);
        return a == ubrs_pkg::OFF_CTRL || a == ubrs_pkg::OFF_DEGLITCH || a == ubrs_pkg::OFF_PRESCALE
            || a == ubrs_pkg::OFF_MOD || a == ubrs_pkg::OFF_STATUS || a == ubrs_pkg::OFF_RXBUF
            || a == ubrs_pkg::OFF_TXBUF;
    endfunction : mapped

    logic [15:0]    ctrl_reg;
    logic [1:0]     deglitch_time_sel_reg;
    logic [15:0]    baud_prescale_value_reg;
    logic [15:0]    mod_reg;
    logic           loopback_enable_reg;
    logic           framing_error_flag_reg, overrun_flag_reg, parity_error_flag_reg, break_detect_flag_reg;
    logic           any_receive_error_flag_reg, addr_idle_flag_reg, port_active_flag_reg, receive_int_flag_reg;
    logic [7:0]     receive_buffer_reg;
    ubrs_rx_state_t rx_state_reg;
    logic [20:0]    rx_cnt_reg;
    logic [3:0]     rx_idx_reg;
    logic [9:0]     rx_bits_reg;
    logic [3:0]     idle_bits_reg;
    logic           idle_before_reg;
    logic           filt_reg;
    logic [5:0]     glitch_cnt_reg;
    ubrs_tx_state_t tx_state_reg;
    logic [11:0]    tx_frame_reg;
    logic [3:0]     tx_idx_reg;
    logic [3:0]     tx_len_reg;
    logic [20:0]    tx_cnt_reg;

    logic        soft_reset_hold, parity_enable, oversample_enable;
    logic [1:0]  async_mode_sel;
    logic [3:0]  first_stage_mod_pattern, nbits;
    logic [7:0]  second_stage_mod_pattern;
    logic        rx_in, acc, fire, rxbuf_rd, rx_done;
    logic [9:0]  rx_mask;
    logic        fe_now, pe_now, oe_now, brk_now, flag1_now;
    logic [5:0]  glitch_cyc;
    logic [11:0] tx_frame;
    logic [31:0] rdata;

    assign soft_reset_hold          = ctrl_reg[ubrs_pkg::CTRL_SWRST_BIT];
    assign async_mode_sel           = ctrl_reg[ubrs_pkg::CTRL_MODE_LSB +: 2];
    assign parity_enable            = ctrl_reg[ubrs_pkg::CTRL_PEN_BIT];
    assign oversample_enable        = mod_reg[ubrs_pkg::MOD_OS16_BIT];
    assign first_stage_mod_pattern  = mod_reg[ubrs_pkg::MOD_BRF_LSB +: 4];
    assign second_stage_mod_pattern = mod_reg[ubrs_pkg::MOD_BRS_LSB +: 8];
    assign rx_in    = loopback_enable_reg ? serial_tx_line : serial_rx_line;
    assign acc      = apb_req.psel & apb_req.penable;
    assign fire     = acc & apb_rsp.pready;
    assign rxbuf_rd = fire & ~apb_req.pwrite & (apb_req.paddr == ubrs_pkg::OFF_RXBUF);
    // Frame length: data, optional address bit, optional parity
    assign nbits    = 4'h8 + {3'h0, async_mode_sel == ubrs_pkg::MODE_ADDR} + {3'h0, parity_enable};
    assign rx_done  = (rx_state_reg == RX_STOP) && (rx_cnt_reg == 21'h1);
    assign rx_mask  = 10'((11'h1 << nbits) - 11'h1);
    assign fe_now   = ~filt_reg;
    assign pe_now   = parity_enable && ((^(rx_bits_reg & rx_mask)) != ~ctrl_reg[ubrs_pkg::CTRL_PSEL_BIT]);
    assign oe_now   = receive_int_flag_reg & ~rxbuf_rd;
    assign brk_now  = ((rx_bits_reg & rx_mask) == 10'h0) && ~filt_reg;
    assign flag1_now = (async_mode_sel == ubrs_pkg::MODE_ADDR) ? rx_bits_reg[8]
                     : (async_mode_sel == ubrs_pkg::MODE_IDLE) & idle_before_reg;

    always_comb begin
        unique case (deglitch_time_sel_reg)
            2'h0: glitch_cyc = 6'(ubrs_pkg::GLITCH0_CYC);
            2'h1: glitch_cyc = 6'(ubrs_pkg::GLITCH1_CYC);
            2'h2: glitch_cyc = 6'(ubrs_pkg::GLITCH2_CYC);
            2'h3: glitch_cyc = 6'(ubrs_pkg::GLITCH3_CYC);
        endcase
    end

    always_comb begin
        tx_frame      = 12'hfff;
        tx_frame[0]   = 1'b0;
        tx_frame[8:1] = apb_req.pwdata[7:0];
        if (async_mode_sel == ubrs_pkg::MODE_ADDR) begin
            tx_frame[9] = ctrl_reg[ubrs_pkg::CTRL_TXADDR_BIT];
        end
        if (parity_enable) begin
            tx_frame[nbits] = ^tx_frame[8:1] ^ ((async_mode_sel == ubrs_pkg::MODE_ADDR) & tx_frame[9])
                            ^ ~ctrl_reg[ubrs_pkg::CTRL_PSEL_BIT];
        end
    end

    always_comb begin
        rdata = 32'h0;
        unique case (apb_req.paddr)
            ubrs_pkg::OFF_CTRL:     rdata[15:0] = ctrl_reg;
            ubrs_pkg::OFF_DEGLITCH: rdata[1:0]  = deglitch_time_sel_reg;
            ubrs_pkg::OFF_PRESCALE: rdata[15:0] = baud_prescale_value_reg;
            ubrs_pkg::OFF_MOD:      rdata[15:0] = {mod_reg[15:4], 3'h0, mod_reg[0]};
            ubrs_pkg::OFF_STATUS:   rdata[7:0]  = {loopback_enable_reg, framing_error_flag_reg, overrun_flag_reg,
                                                   parity_error_flag_reg & parity_enable, break_detect_flag_reg,
                                                   any_receive_error_flag_reg, addr_idle_flag_reg,
                                                   port_active_flag_reg};
            ubrs_pkg::OFF_RXBUF:    rdata[7:0]  = receive_buffer_reg;
            default:                rdata = 32'h0;
        endcase
    end

    // Bus answer: one wait state, then ready
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            apb_rsp <= '0;
        end else begin
            apb_rsp.pready  <= acc & ~apb_rsp.pready;
            apb_rsp.pslverr <= acc & ~apb_rsp.pready & ~mapped(apb_req.paddr);
            apb_rsp.prdata  <= (acc & ~apb_rsp.pready & ~apb_req.pwrite) ? rdata : 32'h0;
        end
    end

    // Configuration registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_reg                <= ubrs_pkg::CTRL_RST;
            deglitch_time_sel_reg   <= ubrs_pkg::DEGLITCH_RST;
            baud_prescale_value_reg <= ubrs_pkg::PRESCALE_RST;
            mod_reg                 <= ubrs_pkg::MOD_RST;
        end else if (fire & apb_req.pwrite) begin
            unique case (apb_req.paddr)
                ubrs_pkg::OFF_CTRL:     ctrl_reg <= apb_req.pwdata[15:0];
                ubrs_pkg::OFF_DEGLITCH: deglitch_time_sel_reg <= apb_req.pwdata[1:0];
                ubrs_pkg::OFF_PRESCALE: baud_prescale_value_reg <= apb_req.pwdata[15:0];
                ubrs_pkg::OFF_MOD:      mod_reg <= {apb_req.pwdata[15:4], 3'h0, apb_req.pwdata[0]};
                default:                ;
            endcase
        end
    end

    // Receive deglitch filter
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            filt_reg       <= 1'b1;
            glitch_cnt_reg <= 6'h0;
        end else if (rx_in == filt_reg) begin
            glitch_cnt_reg <= 6'h0;
        end else if (glitch_cnt_reg + 6'h1 >= glitch_cyc) begin
            filt_reg       <= rx_in;
            glitch_cnt_reg <= 6'h0;
        end else begin
            glitch_cnt_reg <= glitch_cnt_reg + 6'h1;
        end
    end

    // Receiver sequencing
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_state_reg    <= RX_IDLE;
            rx_cnt_reg      <= 21'h1;
            rx_idx_reg      <= 4'h0;
            rx_bits_reg     <= 10'h0;
            idle_bits_reg   <= 4'h0;
            idle_before_reg <= 1'b0;
        end else if (soft_reset_hold) begin
            rx_state_reg    <= RX_IDLE;
            rx_cnt_reg      <= 21'h1;
            idle_bits_reg   <= 4'h0;
            idle_before_reg <= 1'b0;
        end else begin
            rx_cnt_reg <= rx_cnt_reg - 21'h1;
            unique case (rx_state_reg)
                RX_IDLE: begin
                    if (!filt_reg) begin
                        rx_state_reg    <= RX_START;
                        rx_cnt_reg      <= (bit_len(baud_prescale_value_reg, oversample_enable,
                                            first_stage_mod_pattern, second_stage_mod_pattern, 4'h0)
                                            >> 1) | 21'h1;
                        rx_idx_reg      <= 4'h0;
                        idle_before_reg <= idle_bits_reg >= ubrs_pkg::IDLE_BITS;
                        idle_bits_reg   <= 4'h0;
                    end else if (rx_cnt_reg <= 21'h1) begin
                        rx_cnt_reg <= bit_len(baud_prescale_value_reg, oversample_enable,
                                              first_stage_mod_pattern, second_stage_mod_pattern, 4'h0);
                        if (idle_bits_reg < ubrs_pkg::IDLE_BITS) begin
                            idle_bits_reg <= idle_bits_reg + 4'h1;
                        end
                    end
                end
                RX_START, RX_DATA, RX_STOP: begin
                    if (rx_cnt_reg <= 21'h1) begin
                        rx_cnt_reg <= bit_len(baud_prescale_value_reg, oversample_enable,
                                              first_stage_mod_pattern, second_stage_mod_pattern,
                                              rx_idx_reg + 4'h1);
                        if (rx_state_reg == RX_START) begin
                            rx_state_reg <= filt_reg ? RX_IDLE : RX_DATA;
                            rx_idx_reg   <= 4'h0;
                        end else if (rx_state_reg == RX_DATA) begin
                            rx_bits_reg[rx_idx_reg] <= filt_reg;
                            rx_idx_reg              <= rx_idx_reg + 4'h1;
                            if (rx_idx_reg == nbits - 4'h1) begin
                                rx_state_reg <= RX_STOP;
                            end
                        end else begin
                            rx_state_reg <= RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Receive buffer and status flags; a new event wins over a read clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            receive_buffer_reg         <= 8'h0;
            receive_int_flag_reg       <= 1'b0;
            loopback_enable_reg        <= 1'b0;
            framing_error_flag_reg     <= 1'b0;
            overrun_flag_reg           <= 1'b0;
            parity_error_flag_reg      <= 1'b0;
            break_detect_flag_reg      <= 1'b0;
            any_receive_error_flag_reg <= 1'b0;
            addr_idle_flag_reg         <= 1'b0;
        end else if (soft_reset_hold) begin
            receive_int_flag_reg       <= 1'b0;
            framing_error_flag_reg     <= 1'b0;
            overrun_flag_reg           <= 1'b0;
            parity_error_flag_reg      <= 1'b0;
            break_detect_flag_reg      <= 1'b0;
            any_receive_error_flag_reg <= 1'b0;
            addr_idle_flag_reg         <= 1'b0;
            if (fire & apb_req.pwrite & (apb_req.paddr == ubrs_pkg::OFF_STATUS)) begin
                loopback_enable_reg <= apb_req.pwdata[ubrs_pkg::ST_LISTEN_BIT];
            end
        end else if (rx_done) begin
            receive_buffer_reg         <= rx_bits_reg[7:0];
            receive_int_flag_reg       <= 1'b1;
            framing_error_flag_reg     <= fe_now;
            overrun_flag_reg           <= oe_now;
            parity_error_flag_reg      <= pe_now;
            break_detect_flag_reg      <= brk_now;
            any_receive_error_flag_reg <= fe_now | pe_now | oe_now;
            addr_idle_flag_reg         <= flag1_now;
        end else if (rxbuf_rd) begin
            receive_int_flag_reg       <= 1'b0;
            framing_error_flag_reg     <= 1'b0;
            overrun_flag_reg           <= 1'b0;
            parity_error_flag_reg      <= 1'b0;
            break_detect_flag_reg      <= 1'b0;
            any_receive_error_flag_reg <= 1'b0;
            addr_idle_flag_reg         <= 1'b0;
        end
    end

    // Transmitter
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_state_reg   <= TX_IDLE;
            tx_frame_reg   <= 12'hfff;
            tx_idx_reg     <= 4'h0;
            tx_len_reg     <= 4'h0;
            tx_cnt_reg     <= 21'h1;
            serial_tx_line <= 1'b1;
        end else if (soft_reset_hold) begin
            tx_state_reg   <= TX_IDLE;
            serial_tx_line <= 1'b1;
        end else if (tx_state_reg == TX_IDLE) begin
            if (fire & apb_req.pwrite & (apb_req.paddr == ubrs_pkg::OFF_TXBUF)) begin
                tx_state_reg   <= TX_SHIFT;
                tx_frame_reg   <= tx_frame;
                tx_idx_reg     <= 4'h0;
                tx_len_reg     <= nbits + 4'h2;
                serial_tx_line <= 1'b0;
                tx_cnt_reg     <= bit_len(baud_prescale_value_reg, oversample_enable,
                                          first_stage_mod_pattern, second_stage_mod_pattern, 4'h0);
            end
        end else if (tx_cnt_reg <= 21'h1) begin
            if (tx_idx_reg + 4'h1 == tx_len_reg) begin
                tx_state_reg   <= TX_IDLE;
                serial_tx_line <= 1'b1;
            end else begin
                tx_idx_reg     <= tx_idx_reg + 4'h1;
                serial_tx_line <= tx_frame_reg[tx_idx_reg + 4'h1];
                tx_cnt_reg     <= bit_len(baud_prescale_value_reg, oversample_enable,
                                          first_stage_mod_pattern, second_stage_mod_pattern,
                                          tx_idx_reg + 4'h1);
            end
        end else begin
            tx_cnt_reg <= tx_cnt_reg - 21'h1;
        end
    end

    // Activity indication
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            port_active_flag_reg <= 1'b0;
        end else begin
            port_active_flag_reg <= (tx_state_reg != TX_IDLE) | (rx_state_reg != RX_IDLE);
        end
    end

endmodule : ubrs_uart

// file: src/ubrs_pkg.sv
package ubrs_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_DEGLITCH  = 8'h04;
    localparam logic [7:0] OFF_PRESCALE  = 8'h08;
    localparam logic [7:0] OFF_MOD       = 8'h0c;
    localparam logic [7:0] OFF_STATUS    = 8'h10;
    localparam logic [7:0] OFF_RXBUF     = 8'h14;
    localparam logic [7:0] OFF_TXBUF     = 8'h18;

    // Control word fields
    localparam int CTRL_SWRST_BIT = 0;
    localparam int CTRL_TXADDR_BIT = 2;
    localparam int CTRL_MODE_LSB   = 9;
    localparam int CTRL_PSEL_BIT   = 14;
    localparam int CTRL_PEN_BIT    = 15;

    // Modulation word fields
    localparam int MOD_OS16_BIT = 0;
    localparam int MOD_BRF_LSB  = 4;
    localparam int MOD_BRS_LSB  = 8;

    // Status word fields
    localparam int ST_LISTEN_BIT = 7;
    localparam int ST_FE_BIT     = 6;
    localparam int ST_OE_BIT     = 5;
    localparam int ST_PE_BIT     = 4;
    localparam int ST_BRK_BIT    = 3;
    localparam int ST_RXERR_BIT  = 2;
    localparam int ST_ADDR_BIT   = 1;
    localparam int ST_BUSY_BIT   = 0;

    // Reset values
    localparam logic [15:0] CTRL_RST     = 16'h0001;
    localparam logic [1:0]  DEGLITCH_RST = 2'h3;
    localparam logic [15:0] PRESCALE_RST = 16'h0000;
    localparam logic [15:0] MOD_RST      = 16'h0000;
    localparam logic [7:0]  STATUS_RST   = 8'h00;

    // Asynchronous modes
    localparam logic [1:0] MODE_PLAIN    = 2'h0;
    localparam logic [1:0] MODE_IDLE     = 2'h1;
    localparam logic [1:0] MODE_ADDR     = 2'h2;
    localparam logic [1:0] MODE_AUTOBAUD = 2'h3;

    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int GLITCH0_NS    = 2;
    localparam int GLITCH1_NS    = 50;
    localparam int GLITCH2_NS    = 100;
    localparam int GLITCH3_NS    = 200;
    localparam int GLITCH0_CYC   = (GLITCH0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GLITCH1_CYC   = (GLITCH1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GLITCH2_CYC   = (GLITCH2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GLITCH3_CYC   = (GLITCH3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] IDLE_BITS = 4'ha;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ubrs_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ubrs_apb_rsp_t;

endpackage : ubrs_pkg

// file: verification/ubrs_uart_asserts.sv
`timescale 1ns/1ps
module ubrs_uart_asserts (
    // Clock and reset
    input wire logic                    clock,
    input wire logic                    rst,
    // Register bus
    input wire ubrs_pkg::ubrs_apb_req_t apb_req,
    input wire ubrs_pkg::ubrs_apb_rsp_t apb_rsp,
    // Serial lines
    input wire logic                    serial_rx_line,
    input wire logic                    serial_tx_line
);
    logic rd_ok;
    assign rd_ok = apb_rsp.pready && !apb_req.pwrite;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_ready_after: assert property ($rose(apb_req.penable) && apb_req.psel |=> apb_rsp.pready)
        else $error("ready not one cycle after access");
    a_deglitch_rsvd: assert property (
        rd_ok && apb_req.paddr == ubrs_pkg::OFF_DEGLITCH |-> apb_rsp.prdata[31:2] == 30'h0)
        else $error("deglitch reserved bits set");
    a_prescale_width: assert property (
        rd_ok && apb_req.paddr == ubrs_pkg::OFF_PRESCALE |-> apb_rsp.prdata[31:16] == 16'h0)
        else $error("prescaler wider than 16 bits");
    a_mod_rsvd: assert property (
        rd_ok && apb_req.paddr == ubrs_pkg::OFF_MOD |-> {apb_rsp.prdata[31:16], apb_rsp.prdata[3:1]} == 19'h0)
        else $error("modulation reserved bits set");
    a_status_rsvd: assert property (
        rd_ok && apb_req.paddr == ubrs_pkg::OFF_STATUS |-> apb_rsp.prdata[31:8] == 24'h0)
        else $error("status reserved bits set");
    a_error_sum: assert property (
        rd_ok && apb_req.paddr == ubrs_pkg::OFF_STATUS |-> apb_rsp.prdata[2] == |apb_rsp.prdata[6:4])
        else $error("aggregate error flag disagrees");
    a_busy_on_tx: assert property (
        rd_ok && apb_req.paddr == ubrs_pkg::OFF_STATUS && !serial_tx_line && !$past(serial_tx_line)
        |-> apb_rsp.prdata[0]) else $error("busy low while transmitting");
    a_tx_idle_rst: assert property ($past(rst) |-> serial_tx_line [*2])
        else $error("transmit line not idle after reset");
endmodule : ubrs_uart_asserts

bind ubrs_uart ubrs_uart_asserts u_chk (.clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
                                        .serial_rx_line(serial_rx_line), .serial_tx_line(serial_tx_line));

// file: verification/ubrs_remote_node.sv
`timescale 1ns/1ps
module ubrs_remote_node #(
    parameter int BIT_CYC = 8
) (
    // Clock
    input  wire logic clock,
    // Serial line, idle high
    output logic      serial_rx_line
);
    initial serial_rx_line = 1'b1;
    // Start, 8 data LSB first, optional parity, stop
    task automatic send_frame(input logic [7:0] d, input logic par_en, input logic par, input logic stp);
        logic [10:0] bits;
        bits = par_en ? {stp, par, d, 1'b0} : {1'b1, stp, d, 1'b0};
        for (int i = 0; i < (par_en ? 11 : 10); i++) begin
            @(posedge clock);
            serial_rx_line <= bits[i];
            repeat (BIT_CYC - 1) @(posedge clock);
        end
        @(posedge clock);
        serial_rx_line <= 1'b1;
        repeat (2 * BIT_CYC) @(posedge clock);
    endtask : send_frame
endmodule : ubrs_remote_node

// file: verification/ubrs_uart_tb.sv
`timescale 1ns/1ps
module ubrs_uart_tb;
    logic                    clock;
    logic                    rst;
    ubrs_pkg::ubrs_apb_req_t req;
    ubrs_pkg::ubrs_apb_rsp_t rsp;
    logic                    rx_line;
    logic                    tx_line;
    logic [31:0]             rd;
    logic                    err;
    int                      n_mismatch = 0;
    int                      compares   = 0;
    int                      cycles     = 0;

    ubrs_uart dut (.clock(clock), .rst(rst), .apb_req(req), .apb_rsp(rsp), .serial_rx_line(rx_line),
                   .serial_tx_line(tx_line));
    ubrs_remote_node #(.BIT_CYC(8)) remote (.clock(clock), .serial_rx_line(rx_line));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        req <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge clock);
        req.penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        compares++;
        if (rd !== exp) begin
            n_mismatch++;
            $display("MISMATCH reg %h expected %h seen %h", a, exp, rd);
        end
    endtask : rdchk

    task automatic wait_idle();
        do begin
            apb(1'b0, ubrs_pkg::OFF_STATUS, 32'h0);
        end while (rd[0] !== 1'b0);
    endtask : wait_idle

    task automatic t_reset_values();
        rdchk(ubrs_pkg::OFF_CTRL, 32'h1);
        rdchk(ubrs_pkg::OFF_DEGLITCH, 32'h3);
        rdchk(ubrs_pkg::OFF_PRESCALE, 32'h0);
        rdchk(ubrs_pkg::OFF_MOD, 32'h0);
        rdchk(ubrs_pkg::OFF_STATUS, 32'h0);
    endtask : t_reset_values

    task automatic t_reg_access();
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, ubrs_pkg::OFF_DEGLITCH, 32'hffff_fffc | c);
            rdchk(ubrs_pkg::OFF_DEGLITCH, c);
        end
        apb(1'b1, ubrs_pkg::OFF_PRESCALE, 32'hffff_ffff);
        rdchk(ubrs_pkg::OFF_PRESCALE, 32'hffff);
        apb(1'b1, ubrs_pkg::OFF_MOD, 32'hffff_ffff);
        rdchk(ubrs_pkg::OFF_MOD, 32'hfff1);
        apb(1'b1, ubrs_pkg::OFF_STATUS, 32'hffff_ff80);
        rdchk(ubrs_pkg::OFF_STATUS, 32'h80);
        apb(1'b0, 8'h1c, 32'h0);
        compares++;
        if (err !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH pslverr expected 1 seen %b", err);
        end
    endtask : t_reg_access

    task automatic t_loopback();
        apb(1'b1, ubrs_pkg::OFF_DEGLITCH, 32'h0);
        apb(1'b1, ubrs_pkg::OFF_PRESCALE, 32'h8);
        apb(1'b1, ubrs_pkg::OFF_MOD, 32'h0);
        apb(1'b1, ubrs_pkg::OFF_STATUS, 32'h80);
        apb(1'b1, ubrs_pkg::OFF_CTRL, 32'h0);
        apb(1'b1, ubrs_pkg::OFF_TXBUF, 32'h5a);
        rdchk(ubrs_pkg::OFF_STATUS, 32'h81);
        wait_idle();
        rdchk(ubrs_pkg::OFF_STATUS, 32'h80);
        rdchk(ubrs_pkg::OFF_RXBUF, 32'h5a);
        apb(1'b1, ubrs_pkg::OFF_TXBUF, 32'h33);
        wait_idle();
        apb(1'b1, ubrs_pkg::OFF_TXBUF, 32'h44);
        wait_idle();
        rdchk(ubrs_pkg::OFF_STATUS, 32'ha4);
        rdchk(ubrs_pkg::OFF_RXBUF, 32'h44);
        rdchk(ubrs_pkg::OFF_STATUS, 32'h80);
    endtask : t_loopback

    task automatic t_remote();
        apb(1'b1, ubrs_pkg::OFF_CTRL, 32'h1);
        apb(1'b1, ubrs_pkg::OFF_STATUS, 32'h0);
        apb(1'b1, ubrs_pkg::OFF_CTRL, 32'h8000);
        remote.send_frame(8'ha5, 1'b1, 1'b0, 1'b1);
        rdchk(ubrs_pkg::OFF_STATUS, 32'h14);
        rdchk(ubrs_pkg::OFF_RXBUF, 32'ha5);
        remote.send_frame(8'h0f, 1'b1, 1'b1, 1'b0);
        rdchk(ubrs_pkg::OFF_STATUS, 32'h44);
        rdchk(ubrs_pkg::OFF_RXBUF, 32'h0f);
        remote.send_frame(8'h00, 1'b1, 1'b0, 1'b0);
        rdchk(ubrs_pkg::OFF_STATUS, 32'h5c);
        rdchk(ubrs_pkg::OFF_RXBUF, 32'h0);
        rdchk(ubrs_pkg::OFF_STATUS, 32'h0);
    endtask : t_remote

    task automatic t_address();
        apb(1'b1, ubrs_pkg::OFF_CTRL, 32'h1);
        apb(1'b1, ubrs_pkg::OFF_STATUS, 32'h80);
        apb(1'b1, ubrs_pkg::OFF_CTRL, 32'h8404);
        apb(1'b1, ubrs_pkg::OFF_TXBUF, 32'h5a);
        wait_idle();
        rdchk(ubrs_pkg::OFF_STATUS, 32'h82);
        rdchk(ubrs_pkg::OFF_RXBUF, 32'h5a);
        apb(1'b1, ubrs_pkg::OFF_CTRL, 32'h1);
        apb(1'b1, ubrs_pkg::OFF_CTRL, 32'h200);
        apb(1'b1, ubrs_pkg::OFF_TXBUF, 32'h11);
        wait_idle();
        rdchk(ubrs_pkg::OFF_STATUS, 32'h80);
        rdchk(ubrs_pkg::OFF_RXBUF, 32'h11);
        repeat (100) @(posedge clock);
        apb(1'b1, ubrs_pkg::OFF_TXBUF, 32'h22);
        wait_idle();
        rdchk(ubrs_pkg::OFF_STATUS, 32'h82);
        rdchk(ubrs_pkg::OFF_RXBUF, 32'h22);
    endtask : t_address

    task automatic complete_run();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        req = '0;
        rst = 1'b1;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_reset_values();
        t_reg_access();
        t_loopback();
        t_remote();
        t_address();
        complete_run();
    end
endmodule : ubrs_uart_tb
